// [src/ctl_pkg.sv]
// Constants and state codes of the circular trend logger
`default_nettype none
package ctl_pkg;
	// ****************
	// Timing
	// ****************
	localparam int CLK_HZ = 20_000_000;
	localparam int SAMPLE_S = 4;
	localparam int SAMPLE_CYC = CLK_HZ * SAMPLE_S;
	localparam int RING_HOURS = 24;
	localparam int RING_DEPTH = RING_HOURS * 3600 / SAMPLE_S;
	localparam int MIN_SESSION_S = 60;
	localparam int MIN_SAMPLES = MIN_SESSION_S / SAMPLE_S;
	localparam int PB_MIN_PER_S = 20;
	localparam int PB_REC_PER_S = PB_MIN_PER_S * 60 / SAMPLE_S;
	localparam int PB_REC_CYC = CLK_HZ / PB_REC_PER_S;
	localparam int BAUD = 9600;
	localparam int BAUD_CYC = CLK_HZ / BAUD;
	localparam int BEEP_MS = 100;
	localparam int BEEP_CYC = CLK_HZ / 1000 * BEEP_MS;
	localparam int BEEP_COUNT = 3;
	localparam int FRAME_BITS = 11;
	// ****************
	// Record layout and values
	// ****************
	localparam int REC_W = 33;
	localparam int REC_TIME_BIT = 32;
	localparam logic [2:0] TIME_LAST_BYTE = 3'h4;
	localparam logic [2:0] SMP_LAST_BYTE = 3'h1;
	localparam logic [7:0] SPO2_MAX = 8'h64;
	localparam logic [8:0] PR_MIN = 9'h012;
	localparam logic [8:0] PR_FINE_MAX = 9'h0C8;
	localparam logic [8:0] PR_MAX = 9'h12C;
	localparam logic [7:0] PR_CODE_MAX = 8'hFA;
	localparam logic [7:0] BAD_BYTE = 8'hFF;
	localparam logic [7:0] TIME_MARK = 8'hFE;
	// ****************
	// Control states
	// ****************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_REC = 3'b001,
		ST_BEEP = 3'b010,
		ST_PB_RD = 3'b011,
		ST_PB_WAIT = 3'b100,
		ST_SEND = 3'b101,
		ST_TAIL = 3'b110,
		ST_DONE = 3'b111
	} ctl_state_type;
endpackage
`default_nettype wire

// [src/ctl_ring.sv]
// Record ring storage with one write and one registered read port
`default_nettype none
module ctl_ring #(
	parameter int DEPTH = ctl_pkg::RING_DEPTH,
	parameter int W = ctl_pkg::REC_W,
	parameter int AW = $clog2(DEPTH)
) (
	// Clock
	input wire logic clk_i,
	input wire logic ce_i,
	// Write port
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [W-1:0] wdata_i,
	// Read port
	input wire logic [AW-1:0] raddr_i,
	output logic [W-1:0] rdata_o
);
	// ****************
	// Storage
	// ****************
	// No reset: contents must outlive power cycles
	logic [W-1:0] mem_r [DEPTH];

	always_ff @(posedge clk_i) begin
		if (ce_i && we_i) begin
			mem_r[waddr_i] <= wdata_i;
		end
	end

	// Reading never disturbs the contents
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			rdata_o <= mem_r[raddr_i];
		end
	end
endmodule // ctl_ring
`default_nettype wire

// [src/ctl_uart_tx.sv]
// Serial transmitter: start, eight data, ninth bit, stop
`default_nettype none
module ctl_uart_tx #(
	parameter int DIV = ctl_pkg::BAUD_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Byte stream
	input wire logic [7:0] data_i,
	input wire logic par_en_i,
	input wire logic valid_i,
	output logic ready_o,
	// Line
	output logic txd_o
);
	// ****************
	// Shifter
	// ****************
	logic [10:0] shift_r;
	logic [3:0] left_r;
	logic [15:0] div_r;
	wire logic ninth_w;
	wire logic tick_w;
	wire logic load_w;

	// Ninth bit: even parity when asked, else mark
	assign ninth_w = par_en_i ? ^data_i : 1'b1;
	assign tick_w = (div_r == 16'(DIV - 1));
	assign ready_o = (left_r == 4'h0);
	assign load_w = ready_o && valid_i;
	assign txd_o = shift_r[0];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_r <= 11'h7FF;
			left_r <= 4'h0;
			div_r <= 16'h0000;
		end else if (ce_i) begin
			if (load_w) begin
				shift_r <= {1'b1, ninth_w, data_i, 1'b0};
				left_r <= 4'(ctl_pkg::FRAME_BITS);
				div_r <= 16'h0000;
			end else if (!ready_o) begin
				div_r <= tick_w ? 16'h0000 : div_r + 16'h0001;
				if (tick_w) begin
					shift_r <= {1'b1, shift_r[10:1]};
					left_r <= left_r - 4'h1;
				end
			end
		end
	end

	// ****************
	// Checks
	// ****************
	a_frame_start: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && load_w) |=> !txd_o && !ready_o && left_r == 4'(ctl_pkg::FRAME_BITS)
	) else $error("Frame did not open with a start bit");

	a_ninth_bit: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && load_w) |=>
			shift_r[9] == ($past(par_en_i) ? ^$past(data_i) : 1'b1) && shift_r[10]
	) else $error("Ninth bit or stop bit wrong");
endmodule // ctl_uart_tx
`default_nettype wire

// [src/ctl_logger.sv]
// Trend logger: ring recording and newest-first playback
`default_nettype none
// How it works
// - Full ring overwrites the oldest record
// - Ring holds 24 hours of samples
// - Each recording power-on writes a time/date record
// - One saturation and pulse sample per 4 s
// - Saturation stored as whole percent, 0 to 100
// - Pulse 18-200 by one, 201-300 by two
// - No carbon dioxide data stored
// - Recording starts at power-on, not clock-setting
// - Sessions of one minute or less discarded
// - Three beeps, then playback starts unaided
// - Playback runs 20 minutes of data per second
// - Newest record sent first, walking backward
// - Playback leaves records and pointers untouched
// - Invalid reading slots carry byte FF
// - Truncated oldest session start time sent zero
// - Serial 9600 baud, start, nine data, stop
// - Ninth bit is parity during playback
module ctl_logger #(
	parameter int DEPTH = ctl_pkg::RING_DEPTH,
	parameter int SMP_CYC = ctl_pkg::SAMPLE_CYC,
	parameter int REC_CYC = ctl_pkg::PB_REC_CYC,
	parameter int BEEP_CYC = ctl_pkg::BEEP_CYC,
	parameter int BAUD_DIV = ctl_pkg::BAUD_CYC,
	parameter int MIN_SMP = ctl_pkg::MIN_SAMPLES
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Power and keypad events
	input wire logic power_on_i,
	input wire logic power_off_i,
	input wire logic clock_set_i,
	input wire logic pb_entry_i,
	// Readings and time
	input wire logic [31:0] rtc_stamp_i,
	input wire logic [7:0] spo2_i,
	input wire logic [8:0] pr_i,
	input wire logic reading_ok_i,
	// Status and serial line
	output logic recording_o,
	output logic playback_o,
	output logic pb_done_o,
	output logic beep_o,
	output logic txd_o
);
	// ****************
	// Sizes and limits
	// ****************
	localparam int AW = $clog2(DEPTH);
	localparam int RW = ctl_pkg::REC_W;
	localparam int TB = ctl_pkg::REC_TIME_BIT;
	localparam logic [AW:0] FILL_MAX = DEPTH[AW:0];
	localparam logic [AW-1:0] LAST = DEPTH[AW-1:0] - 1'b1;
	localparam logic [31:0] SMP_LAST = 32'(SMP_CYC - 1);
	localparam logic [31:0] PACE_LAST = 32'(REC_CYC - 1);
	localparam logic [31:0] BEEP_LAST = 32'(BEEP_CYC - 1);
	localparam logic [7:0] MIN8 = 8'(MIN_SMP);
	localparam logic [2:0] HALF_LAST = 3'(2 * ctl_pkg::BEEP_COUNT - 1);

	ctl_pkg::ctl_state_type state_r, state_nxt;
	logic [AW-1:0] wr_ptr_r, sess_ptr_r, rd_ptr_r;
	logic [AW:0] fill_r, sess_fill_r, left_r;
	logic [7:0] sess_smp_r;
	logic [31:0] tmr_r, pace_r, beep_r;
	logic [2:0] half_r, byte_r, beeps_r;
	logic [RW-1:0] rec_r;
	logic old_time_r, tail_r, beep_q_r;
	wire logic [RW-1:0] wdata_w, rdata_w;
	wire logic [7:0] tx_data_w;
	wire logic start_rec_w, smp_tick_w, we_w, discard_w;
	wire logic beep_end_w, trunc_w, tx_ready_w, last_w;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ****************
	// Helpers
	// ****************
	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == LAST) ? '0 : p + 1'b1;
	endfunction

	function automatic logic [AW-1:0] ptr_dec(input logic [AW-1:0] p);
		return (p == '0) ? LAST : p - 1'b1;
	endfunction

	function automatic logic [7:0] spo2_code(input logic ok, input logic [7:0] v);
		return (ok && v <= ctl_pkg::SPO2_MAX) ? v : ctl_pkg::BAD_BYTE;
	endfunction

	function automatic logic [7:0] pr_code(input logic ok, input logic [8:0] v);
		logic [8:0] c;
		c = v;
		if (v > ctl_pkg::PR_FINE_MAX) begin
			c = ctl_pkg::PR_FINE_MAX + ((v - ctl_pkg::PR_FINE_MAX + 9'h001) >> 1);
		end
		return (ok && v >= ctl_pkg::PR_MIN && v <= ctl_pkg::PR_MAX) ?
			c[7:0] : ctl_pkg::BAD_BYTE;
	endfunction

	function automatic logic [7:0] rec_byte(input logic [RW-1:0] r, input logic [2:0] i);
		logic [7:0] b;
		b = r[7:0];
		if (r[TB]) begin
			case (i)
				3'h0: b = ctl_pkg::TIME_MARK;
				3'h1: b = r[31:24];
				3'h2: b = r[23:16];
				3'h3: b = r[15:8];
				default: b = r[7:0];
			endcase
		end else if (i == 3'h0) begin
			b = r[15:8];
		end
		return b;
	endfunction

	// ****************
	// Recording decode
	// ****************
	assign start_rec_w = state_r == ctl_pkg::ST_IDLE && power_on_i &&
		!pb_entry_i && !clock_set_i;
	assign smp_tick_w = state_r == ctl_pkg::ST_REC && tmr_r == 32'h0000_0000 &&
		!power_off_i;
	assign we_w = start_rec_w || smp_tick_w;
	// Only saturation, pulse and time reach the ring
	assign wdata_w = start_rec_w ? {1'b1, rtc_stamp_i} :
		{1'b0, 16'h0000, spo2_code(reading_ok_i, spo2_i),
		pr_code(reading_ok_i, pr_i)};
	// Short sessions roll the pointer back; wrapped data already lost stays lost
	assign discard_w = state_r == ctl_pkg::ST_REC && power_off_i &&
		sess_smp_r <= MIN8;

	// ****************
	// Playback decode
	// ****************
	assign beep_end_w = state_r == ctl_pkg::ST_BEEP && beep_r == 32'h0000_0000 &&
		half_r == HALF_LAST;
	assign trunc_w = state_r == ctl_pkg::ST_TAIL && fill_r == FILL_MAX &&
		!old_time_r;
	assign last_w = byte_r == (rec_r[TB] ? ctl_pkg::TIME_LAST_BYTE : ctl_pkg::SMP_LAST_BYTE);
	assign tx_data_w = rec_byte(rec_r, byte_r);
	assign recording_o = state_r == ctl_pkg::ST_REC;
	assign playback_o = state_r[2] || state_r == ctl_pkg::ST_PB_RD;
	assign pb_done_o = state_r == ctl_pkg::ST_DONE;
	assign beep_o = state_r == ctl_pkg::ST_BEEP && !half_r[0];

	// ****************
	// Control
	// ****************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ctl_pkg::ST_IDLE: begin
				if (power_on_i && pb_entry_i) begin
					state_nxt = ctl_pkg::ST_BEEP;
				end else if (start_rec_w) begin
					state_nxt = ctl_pkg::ST_REC;
				end
			end
			ctl_pkg::ST_BEEP: begin
				if (beep_end_w) begin
					state_nxt = ctl_pkg::ST_PB_RD;
				end
			end
			ctl_pkg::ST_PB_RD: begin
				if (left_r == '0) begin
					state_nxt = ctl_pkg::ST_TAIL;
				end else if (pace_r == 32'h0000_0000) begin
					state_nxt = ctl_pkg::ST_PB_WAIT;
				end
			end
			ctl_pkg::ST_PB_WAIT: begin
				state_nxt = ctl_pkg::ST_SEND;
			end
			ctl_pkg::ST_SEND: begin
				if (tx_ready_w && last_w) begin
					state_nxt = tail_r ? ctl_pkg::ST_DONE : ctl_pkg::ST_PB_RD;
				end
			end
			ctl_pkg::ST_TAIL: begin
				state_nxt = trunc_w ? ctl_pkg::ST_SEND : ctl_pkg::ST_DONE;
			end
			default: begin
				state_nxt = state_r;
			end
		endcase
		if (power_off_i && state_r != ctl_pkg::ST_IDLE) begin
			state_nxt = ctl_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ctl_pkg::ST_IDLE;
		end else if (ce_i) begin
			state_r <= state_nxt;
		end
	end

	// ****************
	// Ring pointers
	// ****************
	// Cleared only by battery loss, never by power-off
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_r <= '0;
			fill_r <= '0;
		end else if (ce_i) begin
			if (discard_w) begin
				wr_ptr_r <= sess_ptr_r;
				fill_r <= sess_fill_r;
			end else if (we_w) begin
				wr_ptr_r <= ptr_inc(wr_ptr_r);
				fill_r <= (fill_r == FILL_MAX) ? fill_r : fill_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sess_ptr_r <= '0;
			sess_fill_r <= '0;
			sess_smp_r <= 8'h00;
		end else if (ce_i) begin
			if (start_rec_w) begin
				sess_ptr_r <= wr_ptr_r;
				sess_fill_r <= fill_r;
				sess_smp_r <= 8'h00;
			end else if (smp_tick_w && sess_smp_r <= MIN8) begin
				sess_smp_r <= sess_smp_r + 8'h01;
			end
		end
	end

	// ****************
	// Timers
	// ****************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tmr_r <= 32'h0000_0000;
		end else if (ce_i) begin
			if (start_rec_w || smp_tick_w) begin
				tmr_r <= SMP_LAST;
			end else if (state_r == ctl_pkg::ST_REC) begin
				tmr_r <= tmr_r - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			beep_r <= 32'h0000_0000;
			half_r <= 3'h0;
		end else if (ce_i) begin
			if (state_r != ctl_pkg::ST_BEEP) begin
				beep_r <= BEEP_LAST;
				half_r <= 3'h0;
			end else if (beep_r == 32'h0000_0000) begin
				beep_r <= BEEP_LAST;
				half_r <= half_r + 3'h1;
			end else begin
				beep_r <= beep_r - 32'h0000_0001;
			end
		end
	end

	// ****************
	// Playback walk
	// ****************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_ptr_r <= '0;
			left_r <= '0;
			old_time_r <= 1'b0;
			tail_r <= 1'b0;
		end else if (ce_i) begin
			if (beep_end_w) begin
				rd_ptr_r <= ptr_dec(wr_ptr_r);
				left_r <= fill_r;
				old_time_r <= 1'b1;
				tail_r <= 1'b0;
			end else if (state_r == ctl_pkg::ST_PB_WAIT) begin
				rd_ptr_r <= ptr_dec(rd_ptr_r);
				left_r <= left_r - 1'b1;
				old_time_r <= rdata_w[TB];
			end else if (state_r == ctl_pkg::ST_TAIL) begin
				tail_r <= 1'b1;
			end
		end
	end

	// Pace limits samples only; time records go out at once
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rec_r <= '0;
			byte_r <= 3'h0;
			pace_r <= 32'h0000_0000;
		end else if (ce_i) begin
			if (state_r == ctl_pkg::ST_PB_WAIT) begin
				rec_r <= rdata_w;
				byte_r <= 3'h0;
				pace_r <= rdata_w[TB] ? pace_r : PACE_LAST;
			end else begin
				if (trunc_w) begin
					rec_r <= {1'b1, 32'h0000_0000};
					byte_r <= 3'h0;
				end else if (state_r == ctl_pkg::ST_SEND && tx_ready_w) begin
					byte_r <= byte_r + 3'h1;
				end
				if (pace_r != 32'h0000_0000) begin
					pace_r <= pace_r - 32'h0000_0001;
				end
			end
		end
	end

	// ****************
	// Storage and line
	// ****************
	ctl_ring #(
		.DEPTH(DEPTH),
		.W(RW),
		.AW(AW)
	) u_ring (
		.clk_i(clk_i),
		.ce_i(ce_i),
		.we_i(we_w),
		.waddr_i(wr_ptr_r),
		.wdata_i(wdata_w),
		.raddr_i(rd_ptr_r),
		.rdata_o(rdata_w)
	);

	ctl_uart_tx #(
		.DIV(BAUD_DIV)
	) u_tx (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.data_i(tx_data_w),
		.par_en_i(playback_o),
		.valid_i(state_r == ctl_pkg::ST_SEND),
		.ready_o(tx_ready_w),
		.txd_o(txd_o)
	);

	// ****************
	// Checks
	// ****************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			beep_q_r <= 1'b0;
			beeps_r <= 3'h0;
		end else if (ce_i) begin
			beep_q_r <= beep_o;
			if (state_r != ctl_pkg::ST_BEEP) begin
				beeps_r <= 3'h0;
			end else if (beep_o && !beep_q_r) begin
				beeps_r <= beeps_r + 3'h1;
			end
		end
	end

	sequence s_beep_done;
		ce_i && state_r == ctl_pkg::ST_BEEP && state_nxt == ctl_pkg::ST_PB_RD;
	endsequence

	a_ring_wrap: assert property (
		(ce_i && we_w && wr_ptr_r == LAST) |=> wr_ptr_r == '0
	) else $error("Write pointer did not wrap");

	a_fill_cap: assert property (
		(ce_i && we_w && fill_r == FILL_MAX) |=> fill_r == FILL_MAX
	) else $error("Fill count passed ring size");

	a_time_first: assert property (
		(ce_i && start_rec_w) |=> state_r == ctl_pkg::ST_REC &&
			wr_ptr_r == ptr_inc($past(wr_ptr_r)) && tmr_r == SMP_LAST
	) else $error("Power-on did not store a time record");

	a_sample_tick: assert property (
		(we_w && !wdata_w[TB]) |-> state_r == ctl_pkg::ST_REC && tmr_r == 32'h0000_0000
	) else $error("Sample written off the four second tick");

	a_spo2_range: assert property (
		(we_w && !wdata_w[TB]) |->
			wdata_w[15:8] <= ctl_pkg::SPO2_MAX || wdata_w[15:8] == ctl_pkg::BAD_BYTE
	) else $error("Saturation byte out of range");

	a_pr_top: assert property (
		(we_w && !wdata_w[TB] && reading_ok_i && pr_i == ctl_pkg::PR_MAX) |->
			wdata_w[7:0] == ctl_pkg::PR_CODE_MAX
	) else $error("Top pulse rate coded wrongly");

	a_bad_slot: assert property (
		(we_w && !wdata_w[TB] && !reading_ok_i) |->
			wdata_w[15:0] == {ctl_pkg::BAD_BYTE, ctl_pkg::BAD_BYTE}
	) else $error("Invalid reading not stored as FF");

	a_clkset_idle: assert property (
		(ce_i && state_r == ctl_pkg::ST_IDLE && power_on_i && clock_set_i && !pb_entry_i)
			|=> state_r == ctl_pkg::ST_IDLE && !recording_o
	) else $error("Clock-setting power-on started recording");

	a_short_drop: assert property (
		(ce_i && discard_w) |=> wr_ptr_r == $past(sess_ptr_r) && !recording_o
	) else $error("Short session not discarded");

	a_three_beeps: assert property (
		s_beep_done |-> beeps_r == 3'(ctl_pkg::BEEP_COUNT) ##1 playback_o
	) else $error("Playback began without three beeps");

	a_newest_first: assert property (
		s_beep_done |=> rd_ptr_r == ptr_dec($past(wr_ptr_r)) && left_r == fill_r
	) else $error("Playback did not start at newest record");

	a_pb_keeps: assert property (
		(ce_i && playback_o && !power_off_i) |=>
			wr_ptr_r == $past(wr_ptr_r) && fill_r == $past(fill_r)
	) else $error("Playback altered the ring pointers");

	a_trunc_zero: assert property (
		(ce_i && trunc_w && !power_off_i) |=>
			rec_r == {1'b1, 32'h0000_0000} && state_r == ctl_pkg::ST_SEND
	) else $error("Truncated start time not zero");
endmodule // ctl_logger
`default_nettype wire

// [verification/ctl_serial_rx.sv]
// Serial receiver model standing at the far end of the logger's line
`default_nettype none
module ctl_serial_rx #(
	parameter int DIV = 4
) (
	// Clock
	input wire logic clk_i,
	// Line
	input wire logic rxd_i,
	// Received bytes
	output logic [7:0] byte_o,
	output logic stb_o,
	output logic [15:0] err_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] bits;
	// ****************
	// Frame capture
	// ****************
	// Samples mid-bit, so one cycle of edge skew on the line is tolerated
	initial begin
		byte_o = 8'h00;
		stb_o = 1'b0;
		err_o = 16'h0000;
		forever begin
			@(negedge rxd_i);
			repeat (DIV / 2) @(posedge clk_i);
			if (rxd_i !== 1'b0) err_o = err_o + 16'h0001;
			for (int i = 0; i < 10; i++) begin
				repeat (DIV) @(posedge clk_i);
				bits[i] = rxd_i;
			end
			// Even parity in the ninth bit, stop bit high
			if (bits[8] !== ^bits[7:0] || bits[9] !== 1'b1) err_o = err_o + 16'h0001;
			byte_o = bits[7:0];
			stb_o = 1'b1;
			@(posedge clk_i);
			stb_o = 1'b0;
		end
	end
endmodule  // ctl_serial_rx
`default_nettype wire

// [verification/tb_circular_trend_logger_playback.sv]
// Testbench of the trend logger: sessions, discard, wrap and playback
`default_nettype none
module tb_circular_trend_logger_playback;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// Settings and signals
	// ****************
	localparam int DEPTH = 16;
	localparam int SMP = 40;
	localparam int REC = 400;
	localparam int DIV = 4;
	localparam int MIN_SMP = 2;
	localparam int TIMEOUT = 60000;
	logic clk_i, rst_i, ce_i, power_on_i, power_off_i, clock_set_i, pb_entry_i;
	logic [31:0] rtc_stamp_i;
	logic [7:0] spo2_i;
	logic [8:0] pr_i;
	logic reading_ok_i;
	logic recording_o, playback_o, pb_done_o, beep_o, txd_o;
	logic [7:0] rx_byte;
	logic rx_stb;
	logic [15:0] rx_err;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [32:0] ring_q[$];
	logic wrapped = 1'b0;
	logic [7:0] got_q[$];
	time got_t[$];
	logic [7:0] spo2_tab [8] = '{8'h00, 8'h64, 8'h65, 8'h39, 8'h50, 8'h5A, 8'h62, 8'h10};
	logic [8:0] pr_tab [8] = '{9'h012, 9'h0C8, 9'h0C9, 9'h12C, 9'h011, 9'h12D, 9'h0FA, 9'h03C};
	logic ok_tab [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
	// ****************
	// Design and receiver
	// ****************
	ctl_logger #(.DEPTH(DEPTH), .SMP_CYC(SMP), .REC_CYC(REC), .BEEP_CYC(4), .BAUD_DIV(DIV),
		.MIN_SMP(MIN_SMP)) ctl_logger_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.power_on_i(power_on_i), .power_off_i(power_off_i), .clock_set_i(clock_set_i),
		.pb_entry_i(pb_entry_i), .rtc_stamp_i(rtc_stamp_i), .spo2_i(spo2_i), .pr_i(pr_i),
		.reading_ok_i(reading_ok_i), .recording_o(recording_o), .playback_o(playback_o),
		.pb_done_o(pb_done_o), .beep_o(beep_o), .txd_o(txd_o));
	ctl_serial_rx #(.DIV(DIV)) ctl_serial_rx_inst (.clk_i(clk_i), .rxd_i(txd_o),
		.byte_o(rx_byte), .stb_o(rx_stb), .err_o(rx_err));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc >= TIMEOUT) begin
			num_errors++;
			finish_test();
		end
	end
	always @(negedge clk_i) begin
		if (rx_stb === 1'b1) begin
			got_q.push_back(rx_byte);
			got_t.push_back($time);
		end
	end
	// ****************
	// Helpers
	// ****************
	task automatic check_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	function automatic logic [7:0] spo2_code(input int k);
		return (ok_tab[k] && spo2_tab[k] <= 8'h64) ? spo2_tab[k] : 8'hFF;
	endfunction
	function automatic logic [7:0] pr_code(input int k);
		logic [8:0] p;
		p = pr_tab[k];
		if (!ok_tab[k] || p < 9'h012 || p > 9'h12C) return 8'hFF;
		if (p <= 9'h0C8) return p[7:0];
		return 8'(9'h0C8 + (p - 9'h0C7) / 2);
	endfunction
	task automatic power_up(input logic cs, input logic pb);
		@(negedge clk_i);
		clock_set_i = cs;
		pb_entry_i = pb;
		power_on_i = 1'b1;
		@(negedge clk_i);
		power_on_i = 1'b0;
		clock_set_i = 1'b0;
		pb_entry_i = 1'b0;
	endtask
	task automatic power_down();
		@(negedge clk_i);
		power_off_i = 1'b1;
		@(negedge clk_i);
		power_off_i = 1'b0;
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic record_session(input logic [31:0] stamp, input int n);
		logic [32:0] tmp[$];
		rtc_stamp_i = stamp;
		tmp.push_back({1'b1, stamp});
		power_up(1'b0, 1'b0);
		check_bit(recording_o, 1'b1);
		// Inputs change mid-period, well clear of each sample instant
		repeat (SMP / 2) @(negedge clk_i);
		for (int k = 0; k < n; k++) begin
			spo2_i = spo2_tab[k % 8];
			pr_i = pr_tab[k % 8];
			reading_ok_i = ok_tab[k % 8];
			tmp.push_back({17'h0_0000, spo2_code(k % 8), pr_code(k % 8)});
			repeat (SMP) @(negedge clk_i);
		end
		power_down();
		check_bit(recording_o, 1'b0);
		if (n > MIN_SMP) begin
			foreach (tmp[i]) begin
				ring_q.push_back(tmp[i]);
				if (ring_q.size() > DEPTH) begin
					void'(ring_q.pop_front());
					wrapped = 1'b1;
				end
			end
		end
	endtask
	task automatic clock_set_on();
		// Enable low freezes all state, so this power-on must go unseen
		ce_i = 1'b0;
		power_up(1'b0, 1'b0);
		check_bit(recording_o, 1'b0);
		ce_i = 1'b1;
		power_up(1'b1, 1'b0);
		repeat (SMP * 2) @(negedge clk_i);
		check_bit(recording_o, 1'b0);
		power_down();
	endtask
	task automatic playback();
		logic [7:0] exp_q[$];
		int sidx[$];
		int beeps;
		logic prev;
		logic [32:0] r;
		for (int i = ring_q.size() - 1; i >= 0; i--) begin
			r = ring_q[i];
			if (r[32]) begin
				exp_q = {exp_q, 8'hFE, r[31:24], r[23:16], r[15:8], r[7:0]};
			end else begin
				sidx.push_back(exp_q.size());
				exp_q = {exp_q, r[15:8], r[7:0]};
			end
		end
		if (wrapped && !ring_q[0][32]) exp_q = {exp_q, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h00};
		got_q.delete();
		got_t.delete();
		power_up(1'b0, 1'b1);
		beeps = 0;
		prev = 1'b0;
		for (int i = 0; i < 200 && playback_o !== 1'b1; i++) begin
			if (beep_o === 1'b1 && !prev) beeps++;
			prev = (beep_o === 1'b1);
			@(negedge clk_i);
		end
		check_byte(8'(beeps), 8'h03);
		for (int i = 0; i < 20000 && pb_done_o !== 1'b1; i++) @(negedge clk_i);
		check_bit(pb_done_o, 1'b1);
		// Let the last frame drain through the receiver
		repeat (100) @(negedge clk_i);
		check_byte(8'(got_q.size()), 8'(exp_q.size()));
		for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
			check_byte(got_q[i], exp_q[i]);
		end
		for (int j = 1; j < sidx.size() && sidx[j] < got_t.size(); j++) begin
			check_bit((got_t[sidx[j]] - got_t[sidx[j-1]]) >= REC * 50, 1'b1);
		end
		check_byte(rx_err[7:0], 8'h00);
		power_down();
		check_bit(playback_o, 1'b0);
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		power_on_i = 1'b0;
		power_off_i = 1'b0;
		clock_set_i = 1'b0;
		pb_entry_i = 1'b0;
		rtc_stamp_i = 32'h0000_0000;
		spo2_i = 8'h00;
		pr_i = 9'h000;
		reading_ok_i = 1'b0;
		repeat (16) @(negedge clk_i);
		rst_i = 1'b0;
		check_bit(txd_o, 1'b1);
		check_bit(recording_o, 1'b0);
		record_session(32'h1111_2222, 3);
		record_session(32'h3333_4444, 2);
		clock_set_on();
		playback();
		playback();
		record_session(32'h5555_6666, 14);
		playback();
		finish_test();
	end
endmodule  // tb_circular_trend_logger_playback
`default_nettype wire
